// >>> core/pcs_pkg.sv
// Package for the program counter, return stack and indirect pointer block.
// Shared by the core module and the bench; no other dependencies.
package pcs_pkg;

    // Program counter and stack widths
    localparam int PC_W       = 10;
    localparam int STACK_W    = 12;
    localparam int ADDR_W     = 9;

    // Register file addresses seen on the data port
    localparam logic [6:0] ADDR_INDIRECT_WIN = 7'h00;
    localparam logic [6:0] ADDR_PC_LOW       = 7'h02;
    localparam logic [6:0] ADDR_STATUS       = 7'h03;
    localparam logic [6:0] ADDR_POINTER      = 7'h04;

    // Status register page select position
    localparam int STATUS_PAGE_BIT = 5;
    // Pointer layout
    localparam int PTR_BANK_BIT    = 5;
    localparam int PTR_LOW_W       = 5;

    // Pointer reset values, forced-one pointer masks and the self-reference read value
    localparam logic [7:0] PTR_RST_FLAT   = 8'he0;
    localparam logic [7:0] PTR_RST_BANKED = 8'hc0;
    localparam logic [7:0] PTR_ONES_FLAT  = 8'he0;
    localparam logic [7:0] PTR_ONES_BANK  = 8'hc0;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // Program flow operations from the decoder
    typedef enum logic [2:0] {
        PCS_OP_NEXT   = 3'b000,
        PCS_OP_JUMP   = 3'b001,
        PCS_OP_CALL   = 3'b010,
        PCS_OP_RETLIT = 3'b011,
        PCS_OP_HOLD   = 3'b100
    } pcs_op_t;

endpackage : pcs_pkg

// >>> core/pcs_core.sv
// Program counter, two-level return stack and indirect data addressing.
// Assumes an external decoder issuing one operation per enabled cycle and
// an external register file reached through the translated data port.
`timescale 1ns/1ps

module pcs_core
    import pcs_pkg::*;
#(
    parameter bit BANKED = 1'b1
) (
    input  wire logic             ref_clk_i,
    input  wire logic             srst_i,
    // Instruction cycle enable and decoded operation
    input  wire logic             instr_en_i,
    input  wire logic [2:0]       op_i,
    input  wire logic [8:0]       jump_addr_i,
    input  wire logic [7:0]       literal_i,
    // Data port from the execute stage
    input  wire logic [6:0]       data_addr_i,
    input  wire logic [7:0]       data_wdata_i,
    input  wire logic             data_we_i,
    input  wire logic             data_re_i,
    output logic      [7:0]       data_rdata_o,
    // Translated access to the register file
    output logic      [6:0]       file_addr_o,
    output logic                  file_we_o,
    output logic                  file_re_o,
    output logic      [7:0]       file_wdata_o,
    input  wire logic [7:0]       file_rdata_i,
    // Program flow outputs
    output logic      [PC_W-1:0]  pc_o,
    output logic      [7:0]       work_o,
    output logic                  work_load_o,
    output logic                  page_sel_o
);

    logic [PC_W-1:0]    pc_r;
    logic [PC_W-1:0]    pc_nxt;
    logic [STACK_W-1:0] stack1_r;
    logic [STACK_W-1:0] stack2_r;
    logic [7:0]         ptr_r;
    logic               page_r;
    logic [7:0]         work_r;
    logic               work_load_r;
    logic [7:0]         rdata_r;
    logic [6:0]         eff_addr;
    logic               self_ref;
    logic [PC_W-1:0]    pc_inc;
    logic [STACK_W-1:0] pc_inc_ext;
    logic               pcl_write;

    localparam logic [7:0] PTR_ONES = BANKED ? PTR_ONES_BANK : PTR_ONES_FLAT;
    localparam logic [7:0] PTR_RST  = BANKED ? PTR_RST_BANKED : PTR_RST_FLAT;

    // Map a direct address through the pointer when it hits the window
    function automatic logic [6:0] resolve(input logic [6:0] a,
                                           input logic [7:0] p,
                                           input bit         bank);
        logic [6:0] r;
        r = a;
        if (a == ADDR_INDIRECT_WIN) begin
            // Only the low five bits reach the file, plus the bank bit when BANKED is set
            r = {1'b0, bank ? p[PTR_BANK_BIT] : 1'b0, p[PTR_LOW_W-1:0]};
        end
        return r;
    endfunction : resolve

    assign eff_addr   = resolve(data_addr_i, ptr_r, BANKED);
    assign self_ref   = (data_addr_i == ADDR_INDIRECT_WIN) &&
                        (eff_addr == ADDR_INDIRECT_WIN);
    assign pc_inc     = pc_r + 1'b1;
    assign pc_inc_ext = {{(STACK_W-PC_W){1'b0}}, pc_inc};
    assign pcl_write  = data_we_i && (eff_addr == ADDR_PC_LOW);

    always_comb begin
        pc_nxt = pc_inc;
        if (pcl_write) begin
            pc_nxt = {page_r, 1'b0, data_wdata_i};
        end else begin
            case (op_i)
                PCS_OP_JUMP:   pc_nxt = {page_r, jump_addr_i};
                PCS_OP_CALL:   pc_nxt = {page_r, 1'b0, jump_addr_i[7:0]};
                PCS_OP_RETLIT: pc_nxt = stack1_r[PC_W-1:0];
                PCS_OP_HOLD:   pc_nxt = pc_r;
                default:       pc_nxt = pc_inc;
            endcase
        end
    end

    // Reset points at the calibration slot; stack kept
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pc_r <= '1;
        end else if (instr_en_i) begin
            pc_r <= pc_nxt;
        end
    end

    // Stack has no reset and no overflow tracking
    always_ff @(posedge ref_clk_i) begin
        if (!srst_i && instr_en_i) begin
            if (op_i == PCS_OP_CALL) begin
                stack2_r <= stack1_r;
                stack1_r <= pc_inc_ext;
            end else if (op_i == PCS_OP_RETLIT) begin
                stack1_r <= stack2_r;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            work_r      <= 8'h00;
            work_load_r <= 1'b0;
        end else begin
            work_load_r <= instr_en_i && (op_i == PCS_OP_RETLIT);
            if (instr_en_i && op_i == PCS_OP_RETLIT) begin
                work_r <= literal_i;
            end
        end
    end

    // Page select mirrors the status bit written by software
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            page_r <= 1'b0;
        end else if (data_we_i && eff_addr == ADDR_STATUS) begin
            page_r <= data_wdata_i[STATUS_PAGE_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ptr_r <= PTR_RST;
        end else if (data_we_i && eff_addr == ADDR_POINTER) begin
            ptr_r <= data_wdata_i | PTR_ONES;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_r <= 8'h00;
        end else if (data_re_i) begin
            if (self_ref) begin
                rdata_r <= READ_ZERO;
            end else if (eff_addr == ADDR_PC_LOW) begin
                rdata_r <= pc_r[7:0];
            end else if (eff_addr == ADDR_POINTER) begin
                rdata_r <= ptr_r;
            end else if (eff_addr == ADDR_STATUS) begin
                rdata_r <= {2'b00, page_r, 5'h00};
            end else begin
                rdata_r <= file_rdata_i;
            end
        end
    end

    assign file_addr_o  = eff_addr;
    assign file_we_o    = data_we_i && !self_ref;
    assign file_re_o    = data_re_i && !self_ref;
    assign file_wdata_o = data_wdata_i;
    assign data_rdata_o = rdata_r;
    assign pc_o         = pc_r;
    assign work_o       = work_r;
    assign work_load_o  = work_load_r;
    assign page_sel_o   = page_r;

endmodule : pcs_core

// >>> verification/pcs_sva.sv
// Port checker for pcs_core.
// Bound from the testbench top; one clock, sync reset.
`timescale 1ns/1ps
module pcs_sva
    import pcs_pkg::*;
(
    input wire logic            ref_clk_i,
    input wire logic            srst_i,
    input wire logic            instr_en_i,
    input wire logic [2:0]      op_i,
    input wire logic [8:0]      jump_addr_i,
    input wire logic [7:0]      literal_i,
    input wire logic [6:0]      data_addr_i,
    input wire logic [7:0]      data_wdata_i,
    input wire logic            data_we_i,
    input wire logic            data_re_i,
    input wire logic [6:0]      file_addr_o,
    input wire logic            file_we_o,
    input wire logic            file_re_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic [7:0]      work_o,
    input wire logic            work_load_o,
    input wire logic            page_sel_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (srst_i);
chk_pc_step: assert property (instr_en_i && op_i == 3'h0
    && !data_we_i |=> pc_o == $past(pc_o) + 10'h1) else $error("step");
chk_jump_load: assert property (instr_en_i && op_i == 3'h1
    && !data_we_i |=> pc_o == {$past(page_sel_o), $past(jump_addr_i)})
    else $error("jump");
chk_call_load: assert property (instr_en_i && op_i == 3'h2
    && !data_we_i |=> pc_o[8:0] == ($past(jump_addr_i) & 9'h0ff)
    && pc_o[9] == $past(page_sel_o)) else $error("call");
chk_pcl_load: assert property (data_we_i && data_addr_i == ADDR_PC_LOW
    && instr_en_i
    |=> pc_o == {$past(page_sel_o), 1'h0, $past(data_wdata_i)})
    else $error("pcl");
chk_ret_work: assert property (instr_en_i && op_i == 3'h3
    |=> work_load_o && work_o == $past(literal_i)) else $error("ret");
chk_work_cause: assert property (work_load_o
    |-> $past(instr_en_i) && $past(op_i) == 3'h3) else $error("work");
chk_reset_pc: assert property (disable iff (1'h0) srst_i
    |=> pc_o == 10'h3ff && !page_sel_o) else $error("reset");
chk_self_write: assert property (data_we_i && file_addr_o == 7'h0
    && data_addr_i == ADDR_INDIRECT_WIN |-> !file_we_o) else $error("self");
chk_self_read: assert property (data_re_i && file_addr_o == 7'h0
    && data_addr_i == ADDR_INDIRECT_WIN |-> !file_re_o) else $error("sread");
endmodule : pcs_sva

// >>> verification/testbench.sv
// Bench for pcs_core: flow, stack, reset and indirect access.
// An array stands in for the register file behind the data port.
`timescale 1ns/1ps
module testbench
    import pcs_pkg::*;
;
logic       ref_clk_i = 1'h0, srst_i = 1'h1, instr_en_i = 1'h0;
logic       data_we_i = 1'h0, data_re_i = 1'h0, file_we_o, file_re_o;
logic       work_load_o, page_sel_o;
logic [2:0] op_i = 3'h4;
logic [8:0] jump_addr_i = 9'h0;
logic [7:0] literal_i = 8'h0, data_wdata_i = 8'h0, data_rdata_o;
logic [7:0] work_o, file_wdata_o, mem [64];
logic [6:0] data_addr_i = 7'h0, file_addr_o;
logic [9:0] pc_o;
wire  [7:0] file_rdata_i = mem[file_addr_o[5:0]];
int         bad_count = 0, checked = 0;
initial forever #25 ref_clk_i = ~ref_clk_i;
always @(posedge ref_clk_i)
    if (file_we_o) mem[file_addr_o[5:0]] <= file_wdata_o;
pcs_core #(.BANKED(1'h1)) u_pcs_core (.ref_clk_i, .srst_i, .instr_en_i,
    .op_i, .jump_addr_i, .literal_i, .data_addr_i, .data_wdata_i,
    .data_we_i, .data_re_i, .data_rdata_o, .file_addr_o, .file_we_o,
    .file_re_o, .file_wdata_o, .file_rdata_i, .pc_o, .work_o,
    .work_load_o, .page_sel_o);
task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
    if (got !== exp) bad_count++;
endtask : chk
task automatic op(input logic [2:0] o, input logic [8:0] a,
                  input logic [9:0] e);
    @(posedge ref_clk_i);
    instr_en_i <= 1'h1;
    op_i <= o;
    jump_addr_i <= a;
    literal_i <= a[7:0];
    @(posedge ref_clk_i);
    instr_en_i <= 1'h0;
    #1 chk({2'h0, pc_o}, {2'h0, e});
endtask : op
// Write when w is high, else read and compare with d
task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    data_addr_i <= a;
    data_wdata_i <= d;
    data_we_i <= w;
    data_re_i <= !w;
    @(posedge ref_clk_i);
    data_we_i <= 1'h0;
    data_re_i <= 1'h0;
    #1 if (!w) chk({4'h0, data_rdata_o}, {4'h0, d});
endtask : acc
task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask : stop_test
initial begin
    mem[0] = 8'hff;
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    #1 chk({1'h0, page_sel_o, pc_o}, 12'h3ff);
    op(3'h0, 9'h0, 10'h0);
    op(3'h1, 9'h1a5, 10'h1a5);
    acc(1'h1, ADDR_STATUS, 8'h20);
    op(3'h1, 9'h155, 10'h355);
    // Counter only moves in an instruction cycle, so hold with enable high
    op_i <= PCS_OP_HOLD;
    instr_en_i <= 1'h1;
    acc(1'h1, ADDR_PC_LOW, 8'hc3);
    acc(1'h0, ADDR_PC_LOW, 8'hc3);
    instr_en_i <= 1'h0;
    op(3'h2, 9'h12, 10'h212);
    op(3'h2, 9'h34, 10'h234);
    op(3'h2, 9'h56, 10'h256);
    op(3'h3, 9'h77, 10'h235);
    chk({4'h0, work_o}, 12'h77);
    op(3'h3, 9'h0, 10'h213);
    @(posedge ref_clk_i) srst_i <= 1'h1;
    repeat (4) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    #1 chk({1'h0, page_sel_o, pc_o}, 12'h3ff);
    op(3'h3, 9'h0, 10'h213);
    $display("flow and stack test done");
    acc(1'h1, ADDR_POINTER, 8'h27);
    acc(1'h0, ADDR_POINTER, 8'he7);
    acc(1'h1, ADDR_INDIRECT_WIN, 8'h5a);
    chk({4'h0, mem[6'h27]}, 12'h5a);
    acc(1'h0, ADDR_INDIRECT_WIN, 8'h5a);
    acc(1'h1, ADDR_POINTER, 8'h00);
    acc(1'h1, ADDR_INDIRECT_WIN, 8'haa);
    chk({4'h0, mem[0]}, 12'hff);
    acc(1'h0, ADDR_INDIRECT_WIN, 8'h00);
    acc(1'h0, ADDR_POINTER, 8'hc0);
    $display("indirect test done");
    stop_test();
end
initial begin
    repeat (3000) @(posedge ref_clk_i);
    bad_count++;
    stop_test();
end
endmodule : testbench
bind pcs_core pcs_sva u_pcs_sva (.ref_clk_i, .srst_i, .instr_en_i, .op_i,
    .jump_addr_i, .literal_i, .data_addr_i, .data_wdata_i, .data_we_i,
    .data_re_i, .file_addr_o, .file_we_o, .file_re_o, .pc_o, .work_o,
    .work_load_o, .page_sel_o);
